// file: src/cbc_host.sv
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// ==========================================================
// Transmit buffer host controller
// ==========================================================
// Summary of operation
// - Clearing pending request aborts the message
// - Buffers live in software-placed DMA area
// - Word 0: standard id, SRR, IDE
// - SRR one marks remote request
// - IDE one selects extended identifier
// - Word 1: extended id 17..6
// - Word 2: ext id, RTR, reserved, DLC
// - RTR one marks remote request
// - Software writes reserved bits as zero
// - Words 3-6 payload, even byte low
module cbc_host #(
   parameter int DMA_AW   = 9,
   parameter int POLL_GAP = cbc_pkg::POLL_GAP
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   // Software command port
   input  wire logic [3:0]        swAddr,
   input  wire logic [15:0]       swWdata,
   input  wire logic              swWe,
   input  wire logic              swRe,
   output logic      [15:0]       swRdata,
   // Device register port
   output logic      [7:0]        devAddr,
   output logic      [15:0]       devWdata,
   output logic                   devWe,
   output logic                   devRe,
   input  wire logic [15:0]       devRdata,
   // DMA memory write port
   output logic      [DMA_AW-1:0] dmaAddr,
   output logic      [15:0]       dmaWdata,
   output logic                   dmaWe,
   // Summary status
   output logic                   busy,
   output logic                   done
);

   // ==========================================================
   // Declarations
   // ==========================================================
   cbc_mem_if            stage ();
   cbc_pkg::cbc_state_t  state;
   cbc_pkg::cbc_op_t     curOp;
   cbc_pkg::cbc_op_t     cmdOp;
   logic [2:0]           idx;
   logic                 rdPend;
   logic                 polling;
   logic [2:0]           curBuf;
   logic [1:0]           curPri;
   logic                 curArr;
   logic [15:0]          base;
   logic [7:0]           ctrlAdr;
   logic [7:0]           lastByte;
   logic [15:0]          pollCnt;
   logic                 cmdWrite;
   logic                 cmdGo;
   logic                 abortLate;
   logic                 doneSet;
   logic [7:0]           readByte;

   // ==========================================================
   // Helpers
   // ==========================================================
   // Word address of one word of one buffer inside the area
   function automatic logic [DMA_AW-1:0] buf_addr(input logic [15:0] area,
                                                   input logic [2:0]  bufNo,
                                                   input logic [2:0]  word);
      logic [15:0] sum;
      sum = area + 16'(bufNo) * 16'(cbc_pkg::MSG_WORDS) + 16'(word);
      buf_addr = sum[DMA_AW-1:0];
   endfunction

   // Select the byte of a pair word that serves one buffer
   function automatic logic [7:0] pick_byte(input logic [15:0] pair,
                                            input logic        odd);
      pick_byte = odd ? pair[15:8] : pair[7:0];
   endfunction

   // ==========================================================
   // Staging memory
   // ==========================================================
   cbc_stage_mem #(
      .DEPTH (8)
   ) u_stage (
      .core_clk (core_clk),
      .port     (stage.mem)
   );

   // Software writes to words 0..6 fill the staged message
   assign stage.wrEn   = swWe && (swAddr <= cbc_pkg::SW_STAGE_LAST);
   assign stage.wrAddr = swAddr[2:0];
   assign stage.wrData = swWdata;
   assign stage.rdAddr = idx;

   // ==========================================================
   // Command decode
   // ==========================================================
   assign cmdOp     = cbc_pkg::cbc_op_t'(swWdata[cbc_pkg::CMD_OP_LO +: 2]);
   assign cmdWrite  = swWe && (swAddr == cbc_pkg::SW_CMD);
   assign cmdGo     = cmdWrite && (state == cbc_pkg::S_IDLE) && (cmdOp != cbc_pkg::OP_NONE);
   // Abort accepted while a send is being watched
   assign abortLate = cmdWrite && polling && (cmdOp == cbc_pkg::OP_ABORT)
                      && (curOp == cbc_pkg::OP_SEND);
   assign readByte  = pick_byte(devRdata, curBuf[0]);
   assign doneSet   = (state == cbc_pkg::S_CAPT)
                      && ((curOp == cbc_pkg::OP_STATUS)
                          || (polling && !readByte[cbc_pkg::CB_REQ]));

   // ==========================================================
   // Software configuration registers
   // ==========================================================
   always_ff @(posedge core_clk) begin
      if (rst) begin
         base    <= cbc_pkg::BASE_RST;
         ctrlAdr <= cbc_pkg::CTRLADR_RST;
      end else if (swWe) begin
         if (swAddr == cbc_pkg::SW_BASE) begin
            base <= swWdata;
         end
         if (swAddr == cbc_pkg::SW_CTRLADR) begin
            ctrlAdr <= swWdata[7:0];
         end
      end
   end

   // Done flag: completion wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         done <= 1'b0;
      end else if (doneSet) begin
         done <= 1'b1;
      end else if (swWe && (swAddr == cbc_pkg::SW_STAT) && swWdata[cbc_pkg::ST_DONE]) begin
         done <= 1'b0;
      end
   end

   // ==========================================================
   // Read back, data one cycle after the strobe
   // ==========================================================
   always_ff @(posedge core_clk) begin
      if (rst) begin
         swRdata <= 16'h0000;
      end else if (swRe) begin
         case (swAddr)
            cbc_pkg::SW_BASE:    swRdata <= base;
            cbc_pkg::SW_CTRLADR: swRdata <= {8'h00, ctrlAdr};
            cbc_pkg::SW_STAT:    swRdata <= {lastByte, 5'h00, polling, busy, done};
            default:             swRdata <= 16'h0000;
         endcase
      end else begin
         swRdata <= 16'h0000;
      end
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state    <= cbc_pkg::S_IDLE;
         curOp    <= cbc_pkg::OP_NONE;
         curBuf   <= 3'h0;
         curPri   <= 2'h0;
         curArr   <= 1'b0;
         idx      <= 3'h0;
         rdPend   <= 1'b0;
         polling  <= 1'b0;
         pollCnt  <= 16'h0000;
         lastByte <= 8'h00;
         busy     <= 1'b0;
         devAddr  <= 8'h00;
         devWdata <= 16'h0000;
         devWe    <= 1'b0;
         devRe    <= 1'b0;
         dmaAddr  <= '0;
         dmaWdata <= 16'h0000;
         dmaWe    <= 1'b0;
      end else begin
         devWe <= 1'b0;
         devRe <= 1'b0;
         dmaWe <= 1'b0;
         case (state)
            // Take a command
            cbc_pkg::S_IDLE: begin
               if (cmdGo) begin
                  curOp   <= cmdOp;
                  curBuf  <= swWdata[cbc_pkg::CMD_BUF_LO +: 3];
                  curPri  <= swWdata[cbc_pkg::CMD_PRI_LO +: 2];
                  curArr  <= swWdata[cbc_pkg::CMD_ARR];
                  polling <= 1'b0;
                  busy    <= 1'b1;
                  idx     <= 3'h0;
                  rdPend  <= 1'b0;
                  state   <= (cmdOp == cbc_pkg::OP_SEND) ? cbc_pkg::S_COPY
                                                         : cbc_pkg::S_READ;
               end
            end
            // Copy staged words into the buffer, reserved bits forced low
            cbc_pkg::S_COPY: begin
               if (rdPend) begin
                  dmaWe    <= 1'b1;
                  dmaAddr  <= buf_addr(base, curBuf, idx - 3'h1);
                  // Fields kept in place, unused and reserved bits zero
                  dmaWdata <= stage.rdData & cbc_pkg::word_mask(idx - 3'h1);
               end
               if (idx != cbc_pkg::TX_WORDS) begin
                  idx    <= idx + 3'h1;
                  rdPend <= 1'b1;
               end else begin
                  rdPend <= 1'b0;
                  state  <= cbc_pkg::S_READ;
               end
            end
            // Read the pair control register
            cbc_pkg::S_READ: begin
               devRe   <= 1'b1;
               devAddr <= ctrlAdr + {6'h00, curBuf[2:1]};
               state   <= cbc_pkg::S_WAIT;
            end
            // Device answers one cycle after its strobe
            cbc_pkg::S_WAIT: begin
               state <= cbc_pkg::S_CAPT;
            end
            // Decide on the returned control byte
            cbc_pkg::S_CAPT: begin
               lastByte <= readByte;
               if (curOp == cbc_pkg::OP_STATUS) begin
                  busy  <= 1'b0;
                  state <= cbc_pkg::S_IDLE;
               end else if (polling) begin
                  // Request cleared: sent, or abandoned after abort
                  if (!readByte[cbc_pkg::CB_REQ]) begin
                     busy    <= 1'b0;
                     polling <= 1'b0;
                     state   <= cbc_pkg::S_IDLE;
                  end else begin
                     pollCnt <= 16'h0000;
                     state   <= cbc_pkg::S_POLL;
                  end
               end else begin
                  // Read-only flags written as zero, the device ignores them
                  devWdata <= curBuf[0]
                     ? {ctl_byte(readByte), flags_off(devRdata[7:0])}
                     : {flags_off(devRdata[15:8]), ctl_byte(readByte)};
                  state <= cbc_pkg::S_WRITE;
               end
            end
            // Write back the pair, then watch the request bit
            cbc_pkg::S_WRITE: begin
               devWe   <= 1'b1;
               polling <= 1'b1;
               pollCnt <= 16'h0000;
               state   <= cbc_pkg::S_POLL;
            end
            // Gap between polls; an abort may cut in here
            cbc_pkg::S_POLL: begin
               if (abortLate || (pollCnt == 16'(POLL_GAP - 1))) begin
                  state <= cbc_pkg::S_READ;
               end else begin
                  pollCnt <= pollCnt + 16'h0001;
               end
            end
            default: begin
               busy  <= 1'b0;
               state <= cbc_pkg::S_IDLE;
            end
         endcase
         // Abort cuts in wherever a send is watched, so none is lost mid-read
         if (abortLate) begin
            curOp   <= cbc_pkg::OP_ABORT;
            polling <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Control byte composition
   // ==========================================================
   // New byte for this buffer, by current operation
   function automatic logic [7:0] ctl_byte(input logic [7:0] old);
      logic [7:0] b;
      b = 8'h00;
      if (curOp == cbc_pkg::OP_SEND) begin
         b[cbc_pkg::CB_DIR]        = 1'b1;
         b[cbc_pkg::CB_REQ]        = 1'b1;
         b[cbc_pkg::CB_ARR]        = curArr;
         b[cbc_pkg::CB_PRI +: 2]   = curPri;
      end else begin
         b                         = flags_off(old);
         b[cbc_pkg::CB_REQ]        = 1'b0;
      end
      ctl_byte = b;
   endfunction

   // Neighbour byte kept, its read-only flags dropped
   function automatic logic [7:0] flags_off(input logic [7:0] b);
      logic [7:0] r;
      r = b;
      r[cbc_pkg::CB_ABT]  = 1'b0;
      r[cbc_pkg::CB_LARB] = 1'b0;
      r[cbc_pkg::CB_TERR] = 1'b0;
      flags_off = r;
   endfunction

endmodule

// file: src/cbc_mem_if.sv
`timescale 1ns/1ps
// ==========================================================
// Staging memory carrier
// ==========================================================
interface cbc_mem_if;
   logic        wrEn;
   logic [2:0]  wrAddr;
   logic [15:0] wrData;
   logic [2:0]  rdAddr;
   logic [15:0] rdData;

   modport user (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
   modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// file: src/cbc_pkg.sv
package cbc_pkg;

   // ==========================================================
   // Software register offsets (word index on the command port)
   // ==========================================================
   localparam logic [3:0] SW_STAGE_LAST = 4'h6;   // Staging words 0..6 at 0x0..0x6
   localparam logic [3:0] SW_BASE       = 4'h8;   // Buffer area base, in words
   localparam logic [3:0] SW_CMD        = 4'h9;   // Command
   localparam logic [3:0] SW_STAT       = 4'ha;   // Status, write 1 to bit 0 clears done
   localparam logic [3:0] SW_CTRLADR    = 4'hb;   // Device address of pair register 0

   // Command field positions
   localparam int CMD_BUF_LO = 0;                 // Bits 2..0 buffer number
   localparam int CMD_PRI_LO = 3;                 // Bits 4..3 priority
   localparam int CMD_ARR    = 5;                 // Auto-remote reply enable
   localparam int CMD_OP_LO  = 6;                 // Bits 7..6 opcode

   // Status field positions
   localparam int ST_DONE    = 0;

   // Reset values
   localparam logic [15:0] BASE_RST    = 16'h0000;
   localparam logic [7:0]  CTRLADR_RST = 8'h00;

   // ==========================================================
   // Pair control byte layout
   // ==========================================================
   localparam int CB_DIR  = 7;                    // 1 transmit, 0 receive
   localparam int CB_ABT  = 6;                    // Message aborted (read only)
   localparam int CB_LARB = 5;                    // Arbitration lost (read only)
   localparam int CB_TERR = 4;                    // Bus error while sending (read only)
   localparam int CB_REQ  = 3;                    // Send request
   localparam int CB_ARR  = 2;                    // Auto-remote reply enable
   localparam int CB_PRI  = 0;                    // Bits 1..0 priority

   // ==========================================================
   // Message buffer layout in DMA memory
   // ==========================================================
   localparam logic [3:0]  MSG_WORDS  = 4'h8;     // Words per buffer
   localparam logic [2:0]  TX_WORDS   = 3'h7;     // Words the host writes (0..6)
   localparam logic [15:0] W0_MASK    = 16'h1fff; // Id 12-2, SRR 1, IDE 0
   localparam logic [15:0] W1_MASK    = 16'h0fff; // Ext id 17..6
   localparam logic [15:0] W2_MASK    = 16'hfe0f; // Ext id, RTR, DLC; reserved zero
   localparam logic [15:0] DATA_MASK  = 16'hffff; // Payload bytes, even byte low

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int POLL_GAP = 16;                  // Cycles between status polls

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      OP_NONE   = 2'b00,
      OP_SEND   = 2'b01,
      OP_ABORT  = 2'b10,
      OP_STATUS = 2'b11
   } cbc_op_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_COPY  = 3'b001,
      S_READ  = 3'b011,
      S_WAIT  = 3'b010,
      S_CAPT  = 3'b110,
      S_WRITE = 3'b111,
      S_POLL  = 3'b101
   } cbc_state_t;

   // Mask of the bits a word may carry out to the buffer
   function automatic logic [15:0] word_mask(input logic [2:0] idx);
      case (idx)
         3'h0:    word_mask = W0_MASK;
         3'h1:    word_mask = W1_MASK;
         3'h2:    word_mask = W2_MASK;
         default: word_mask = DATA_MASK;
      endcase
   endfunction

endpackage

// file: src/cbc_stage_mem.sv
`timescale 1ns/1ps
// ==========================================================
// Message staging memory, registered read
// ==========================================================
module cbc_stage_mem #(
   parameter int DEPTH = 8
) (
   input  wire logic core_clk,
   cbc_mem_if.mem    port
);
   logic [15:0] words [DEPTH];

   // Software side write
   always_ff @(posedge core_clk) begin
      if (port.wrEn) begin
         words[port.wrAddr] <= port.wrData;
      end
   end

   // Registered read for the sequencer
   always_ff @(posedge core_clk) begin
      port.rdData <= words[port.rdAddr];
   end
endmodule

// file: verif/can_tx_buffer_control_and_message_layout_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module can_tx_buffer_control_and_message_layout_tb;
   logic        core_clk, rst, swWe, swRe, stall, devWe, devRe, dmaWe, busy, done;
   logic [3:0]  swAddr;
   logic [15:0] swWdata, swRdata, devWdata, devRdata, dmaWdata;
   logic [7:0]  devAddr;
   logic [8:0]  dmaAddr;
   logic [1:0]  evt;
   logic [2:0]  evtBuf;
   int          fails, checks_done;

   cbc_host #(.DMA_AW(9), .POLL_GAP(2)) cbc_host_inst (.core_clk(core_clk), .rst(rst),
      .swAddr(swAddr), .swWdata(swWdata), .swWe(swWe), .swRe(swRe), .swRdata(swRdata),
      .devAddr(devAddr), .devWdata(devWdata), .devWe(devWe), .devRe(devRe),
      .devRdata(devRdata), .dmaAddr(dmaAddr), .dmaWdata(dmaWdata), .dmaWe(dmaWe),
      .busy(busy), .done(done));
   cbc_dev_model cbc_dev_model_inst (
      .core_clk(core_clk), .rst(rst), .devAddr(devAddr), .devWdata(devWdata),
      .devWe(devWe), .devRe(devRe), .devRdata(devRdata), .dmaAddr(dmaAddr),
      .dmaWdata(dmaWdata), .dmaWe(dmaWe), .stall(stall), .evt(evt), .evtBuf(evtBuf));

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Bits a buffer word may carry
   logic [15:0] keep [7] = '{16'h1fff, 16'h0fff, 16'hfe0f, 16'hffff, 16'hffff, 16'hffff, 16'hffff};

   task automatic swWrite(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      swWe    <= 1'b1;
      swAddr  <= a;
      swWdata <= d;
      @(posedge core_clk);
      swWe <= 1'b0;
   endtask

   task automatic swRead(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      swRe   <= 1'b1;
      swAddr <= a;
      @(posedge core_clk);
      swRe <= 1'b0;
      @(negedge core_clk);
      d = swRdata;
   endtask

   // Clear done, then issue a command
   task automatic command(input logic [1:0] op, input logic [2:0] b, input logic [2:0] cfg);
      swWrite(4'ha, 16'h0001);
      swWrite(4'h9, {8'h00, op, cfg, b});
   endtask

   task automatic waitDone();
      for (int n = 0; n < 400 && done !== 1'b1; n++)
         @(negedge core_clk);
      `CHK("done", 1'b1, done)
   endtask

   // Status command, then compare the reported control byte
   task automatic stat(input logic [2:0] b, input logic [7:0] m, input logic [7:0] ex);
      logic [15:0] r;
      command(2'b11, b, 3'h0);
      waitDone();
      swRead(4'ha, r);
      `CHK("control byte", ex, r[15:8] & m)
   endtask

   task automatic results();
      $display("Comparisons %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      results();
   end

   initial begin
      logic [15:0] r;
      rst = 1'b1;
      swWe = 1'b0;
      swRe = 1'b0;
      swAddr = 4'h0;
      swWdata = 16'h0000;
      stall = 1'b0;
      evt = 2'b00;
      evtBuf = 3'h0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      swRead(4'ha, r);
      `CHK("status at reset", 16'h0000, r)
      swRead(4'hc, r);
      `CHK("unmapped read", 16'h0000, r)
      swWrite(4'h8, 16'h0010);
      swWrite(4'hb, 16'h0020);
      for (int w = 0; w < 7; w++)
         swWrite(4'(w), 16'hfff0 | 16'(w));
      // Every priority code, even and odd buffers, a refused send while busy
      for (int b = 0; b < 4; b++) begin
         command(2'b01, 3'(b), {b[0], 2'(b)});
         swWrite(4'h9, 16'h0047);
         waitDone();
         stat(3'(b), 8'hff, {5'b10000, b[0], 2'(b)});
         for (int w = 0; w < 7; w++)
            `CHK("buffer word", (16'hfff0 | 16'(w)) & keep[w],
                 cbc_dev_model_inst.mem[16 + b * 8 + w])
      end
      stat(3'h7, 8'hff, 8'h00);
      // Arbitration loss and bus error, then abort
      stall <= 1'b1;
      command(2'b01, 3'h4, 3'h7);
      for (int n = 0; n < 100 && cbc_dev_model_inst.ctl[4][3] !== 1'b1; n++)
         @(negedge core_clk);
      @(posedge core_clk);
      evtBuf <= 3'h4;
      evt <= 2'b10;
      @(posedge core_clk);
      evt <= 2'b11;
      @(posedge core_clk);
      evt <= 2'b00;
      command(2'b10, 3'h0, 3'h0);
      waitDone();
      stat(3'h4, 8'h78, 8'h70);
      // Resend clears the flags
      stall <= 1'b0;
      command(2'b01, 3'h4, 3'h7);
      waitDone();
      stat(3'h4, 8'hff, 8'h87);
      // Remote frame requeues the message
      stall <= 1'b1;
      @(posedge core_clk);
      evt <= 2'b01;
      @(posedge core_clk);
      evt <= 2'b00;
      stat(3'h4, 8'hff, 8'h8f);
      stall <= 1'b0;
      results();
   end
endmodule

// file: verif/cbc_dev_model.sv
`timescale 1ns/1ps
// ==========================================================
// Controller device model: pair registers and DMA memory
// ==========================================================
module cbc_dev_model #(
   parameter int         DMA_AW   = 9,
   parameter logic [7:0] CTRL_ADR = 8'h20,
   parameter int         DELAY    = 5
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [7:0]        devAddr,
   input  wire logic [15:0]       devWdata,
   input  wire logic              devWe,
   input  wire logic              devRe,
   output logic      [15:0]       devRdata,
   input  wire logic [DMA_AW-1:0] dmaAddr,
   input  wire logic [15:0]       dmaWdata,
   input  wire logic              dmaWe,
   input  wire logic              stall,
   input  wire logic [1:0]        evt,
   input  wire logic [2:0]        evtBuf
);
   logic [7:0]  ctl [8];
   logic [15:0] mem [2**DMA_AW];
   logic [7:0]  cnt;
   logic [7:0]  off;
   int          win;

   assign off = devAddr - CTRL_ADR;

   // Pending transmit with the highest priority, ties to lower number
   always_comb begin
      win = -1;
      for (int b = 0; b < 8; b++)
         if (ctl[b][7] && ctl[b][3] && (win < 0 || ctl[b][1:0] > ctl[win][1:0]))
            win = b;
   end

   // Read answer one cycle later; garbage outside the slot
   always_ff @(posedge core_clk) begin
      if (rst)
         devRdata <= 16'h0000;
      else if (devRe && off < 8'h04)
         devRdata <= {ctl[{off[1:0], 1'b1}], ctl[{off[1:0], 1'b0}]};
      else
         devRdata <= ~devRdata;
   end

   // Pair register writes, sending and bus events
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int b = 0; b < 8; b++)
            ctl[b] <= 8'h00;
         cnt <= 8'h00;
      end else begin
         for (int b = 0; b < 8; b++) begin
            if (devWe && off < 8'h04 && b / 2 == int'(off)) begin
               if (devWdata[8*(b%2)+3] && !ctl[b][3])
                  ctl[b][6:4] <= 3'b000;
               else if (!devWdata[8*(b%2)+3] && ctl[b][3])
                  ctl[b][6] <= 1'b1;
               ctl[b][7] <= devWdata[8*(b%2)+7];
               ctl[b][3:0] <= devWdata[8*(b%2) +: 4];
            end
         end
         if (win >= 0 && !stall)
            cnt <= cnt + 8'h01;
         if (win >= 0 && !stall && cnt == 8'(DELAY)) begin
            ctl[win][3] <= 1'b0;
            cnt <= 8'h00;
         end
         if (evt == 2'b01 && ctl[evtBuf][2])
            ctl[evtBuf][6:3] <= 4'b0001;
         if (evt == 2'b10 && ctl[evtBuf][3])
            ctl[evtBuf][5] <= 1'b1;
         if (evt == 2'b11 && ctl[evtBuf][3])
            ctl[evtBuf][4] <= 1'b1;
      end
   end

   // Message buffer area in DMA memory
   always_ff @(posedge core_clk) begin
      if (dmaWe)
         mem[dmaAddr] <= dmaWdata;
   end
endmodule

// file: verif/cbc_host_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Host port checker
// ==========================================================
module cbc_host_assertions #(
   parameter int DMA_AW   = 9,
   parameter int POLL_GAP = 16
) (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic [3:0]        swAddr,
   input wire logic [15:0]       swWdata,
   input wire logic              swWe,
   input wire logic              swRe,
   input wire logic [15:0]       swRdata,
   input wire logic [7:0]        devAddr,
   input wire logic [15:0]       devWdata,
   input wire logic              devWe,
   input wire logic              devRe,
   input wire logic [15:0]       devRdata,
   input wire logic [DMA_AW-1:0] dmaAddr,
   input wire logic [15:0]       dmaWdata,
   input wire logic              dmaWe,
   input wire logic              busy,
   input wire logic              done
);
   logic [1:0]  curOp;
   logic [2:0]  curBuf;
   logic [2:0]  curCfg;
   logic [15:0] baseReg;
   logic [7:0]  ctrlAdr;
   wire  [7:0]  selByte = curBuf[0] ? devWdata[15:8] : devWdata[7:0];
   wire  [7:0]  othByte = curBuf[0] ? devWdata[7:0] : devWdata[15:8];
   wire         cmdGo   = swWe && swAddr == 4'h9 && swWdata[7:6] != 2'b00 && !busy;
   wire         sendGo  = cmdGo && swWdata[7:6] == 2'b01;

   // Track the command in flight and the software settings
   always_ff @(posedge core_clk) begin
      if (rst) begin
         curOp   <= 2'b00;
         curBuf  <= 3'h0;
         curCfg  <= 3'h0;
         baseReg <= 16'h0000;
         ctrlAdr <= 8'h00;
      end else begin
         if (cmdGo) begin
            curOp  <= swWdata[7:6];
            curBuf <= swWdata[2:0];
            curCfg <= swWdata[5:3];
         end else if (swWe && swAddr == 4'h9 && busy && swWdata[7:6] == 2'b10) begin
            curOp <= 2'b10;
         end
         if (swWe && swAddr == 4'h8)
            baseReg <= swWdata;
         if (swWe && swAddr == 4'hb)
            ctrlAdr <= swWdata[7:0];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ==========================================================
   // Assertions
   // ==========================================================
   a_reset_quiet: assert property (
      disable iff (1'b0) rst |=> !busy && !done && !devWe && !devRe && !dmaWe)
      else $error("outputs active after reset");
   a_rdata_idle: assert property (
      !$past(swRe) |-> swRdata == 16'h0000) else $error("read data outside read slot");
   a_status_walk: assert property (
      cmdGo && swWdata[7:6] == 2'b11 |-> ##2 devRe ##3 (done && !busy))
      else $error("status command timing wrong");
   a_send_burst: assert property (
      sendGo |-> ##3 dmaWe [*7] ##1 !dmaWe) else $error("buffer copy not seven words");
   a_dma_place: assert property (
      sendGo |-> ##3 dmaAddr == DMA_AW'(baseReg + 16'($past(swWdata[2:0], 3)) * 16'h0008))
      else $error("buffer copy at wrong address");
   a_dma_order: assert property (
      dmaWe && $past(dmaWe) |-> dmaAddr == $past(dmaAddr) + 1'b1)
      else $error("buffer words out of order");
   a_send_write: assert property (
      sendGo |-> ##10 devRe ##3 devWe) else $error("request write not issued");
   a_ctrl_byte: assert property (
      devWe && curOp == 2'b01 |-> selByte == {4'b1000, 1'b1, curCfg} &&
      othByte[6:4] == 3'b000 && devAddr == ctrlAdr + 8'(curBuf[2:1]))
      else $error("control byte written wrong");
   a_abort_byte: assert property (
      devWe && curOp == 2'b10 |-> selByte[3] == 1'b0) else $error("abort left request set");
   a_done_ends: assert property (
      $rose(done) |-> !busy && $past(busy)) else $error("done without busy end");

   c_send: cover property (sendGo);
   c_abort: cover property (devWe && curOp == 2'b10);
   c_status: cover property (cmdGo && swWdata[7:6] == 2'b11);
endmodule

bind cbc_host cbc_host_assertions #(.DMA_AW(DMA_AW), .POLL_GAP(POLL_GAP))
   cbc_host_assertions_inst (
   .core_clk(core_clk), .rst(rst), .swAddr(swAddr), .swWdata(swWdata), .swWe(swWe),
   .swRe(swRe), .swRdata(swRdata), .devAddr(devAddr), .devWdata(devWdata), .devWe(devWe),
   .devRe(devRe), .devRdata(devRdata), .dmaAddr(dmaAddr), .dmaWdata(dmaWdata),
   .dmaWe(dmaWe), .busy(busy), .done(done));
